// File: bench/pwcog_props.sv
`timescale 1ns/10ps
`default_nettype none
module pwcog_props
    import pwcog_pkg::*;
#(
    parameter int NUM_PINS = 8
)(
    // Clock and reset.
    input wire logic                   clk_i,
    input wire logic                   sys_rst_i,
    // Register bus.
    input wire logic                   avs_read_i,
    input wire logic                   avs_write_i,
    input wire logic [4:0]             avs_address_i,
    input wire logic [31:0]            avs_writedata_i,
    input wire logic [31:0]            avs_readdata_o,
    input wire logic                   avs_waitrequest_o,
    // Pin side.
    input wire logic [NUM_PINS-1:0]    timer_level_i,
    input wire logic [NUM_PINS-1:0]    port_level_i,
    input wire logic [NUM_PINS-1:0]    port_oe_n_i,
    input wire logic                   cutoff_event_i,
    input wire logic                   ext_clk_i,
    input wire pwcog_pkg::pwcog_pins_t pins_o,
    input wire logic                   count_tick_o,
    input wire logic [2:0]             counter_clear_sel_o
);
    import pwcog_pkg::*;
    //--------------------------------------------------------------------------
    // Shadow registers and expected pin state
    //--------------------------------------------------------------------------
    logic [7:0] sel0, sel1, dis, ctl, next_sel0, next_sel1, next_dis, next_ctl;
    logic [7:0] xl, mfl, md, mt;
    logic [1:0] s;
    logic       cut, next_cut, tk, rst_q;

    // Shadows follow writes at the edge that completes them, where the
    // master sees waitrequest low; set of the latch wins over its clear.
    always_comb begin
        tk = avs_write_i && !avs_waitrequest_o;
        next_sel0 = (tk && avs_address_i == OFS_CUTOFF_SELECT_CH0) ?
                    avs_writedata_i[7:0] : sel0;
        next_sel1 = (tk && avs_address_i == OFS_CUTOFF_SELECT_CH1) ?
                    avs_writedata_i[7:0] : sel1;
        next_dis = (tk && avs_address_i == OFS_OUTPUT_DISABLE) ?
                   avs_writedata_i[7:0] : dis;
        next_ctl = (tk && avs_address_i == OFS_COUNTER0_CONTROL) ?
                   avs_writedata_i[7:0] : ctl;
        next_cut = cutoff_event_i || (cut && !(tk && avs_writedata_i[0] &&
                   avs_address_i == OFS_CUTOFF_STATUS));
        for (int p = 0; p < 8; p++) begin
            s = (p < 4) ? sel0[7-2*p -: 2] : sel1[15-2*p -: 2];
            md[p] = (cut || cutoff_event_i) && s[1] && !dis[p];
            mfl[p] = (cut || cutoff_event_i) && s == CUT_FLOAT && !dis[p];
            mt[p] = !dis[p] && !md[p] && !mfl[p];
            xl[p] = s[0];
        end
    end

    // Shadow state, cleared by reset like the block's own registers.
    always_ff @(posedge clk_i) begin
        {sel0, sel1, dis, ctl, cut} <= sys_rst_i ? 33'h0 :
            {next_sel0, next_sel1, next_dis, next_ctl, next_cut};
    end

    // The release edge still registers reset values into the pins, so
    // attempts there are masked by a one-cycle delayed copy of reset.
    always_ff @(posedge clk_i) begin
        rst_q <= sys_rst_i;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || rst_q);

    AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer is not one cycle long");
    AST_CUT_FLOAT: assert property (1'b1 |=>
        (~pins_o.oe_n & $past(mfl)) == 8'h00) else $error("pin not floated");
    AST_CUT_CH1: assert property (1'b1 |=>
        (((pins_o.level ^ $past(xl)) | pins_o.oe_n) & $past(md) & 8'hF0)
        == 8'h00) else $error("channel 1 forced level wrong");
    AST_CUT_D0: assert property (1'b1 |=>
        (((pins_o.level ^ $past(xl)) | pins_o.oe_n) & $past(md) & 8'h08)
        == 8'h00) else $error("pin d0 forced level wrong");
    AST_TIMER_DRIVE: assert property (1'b1 |=>
        (((pins_o.level ^ $past(timer_level_i)) | pins_o.oe_n) & $past(mt))
        == 8'h00) else $error("timer level not driven");
    AST_PORT_HANDOVER: assert property (1'b1 |=>
        (((pins_o.level ^ $past(port_level_i)) |
        (pins_o.oe_n ^ $past(port_oe_n_i))) & $past(dis)) == 8'h00)
        else $error("disabled pin not handed to port");
    AST_CLEAR_SEL: assert property ($stable(ctl)[*2] |->
        counter_clear_sel_o == ctl[7:5]) else $error("clear select wrong");
    AST_TICK_FULL: assert property ((ctl[2:0] == 3'h0)[*4] |->
        count_tick_o) else $error("undivided source missed a tick");
    AST_CUT_HOLD: assert property (cut && !cutoff_event_i |=>
        (((pins_o.level ^ $past(xl)) | pins_o.oe_n) & $past(md)) == 8'h00)
        else $error("forced state not held");
endmodule

bind pwcog_top pwcog_props #(.NUM_PINS(NUM_PINS)) u_pwcog_props (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_address_i(avs_address_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .timer_level_i(timer_level_i),
    .port_level_i(port_level_i), .port_oe_n_i(port_oe_n_i),
    .cutoff_event_i(cutoff_event_i), .ext_clk_i(ext_clk_i), .pins_o(pins_o),
    .count_tick_o(count_tick_o), .counter_clear_sel_o(counter_clear_sel_o));
`default_nettype wire

// File: bench/pwcog_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
module pwcog_stage_model
    import pwcog_pkg::*;
(
    // Pins from the block.
    input  wire pwcog_pkg::pwcog_pins_t pins_i,
    // Level seen by each gate driver.
    output logic [7:0]                  gate_o
);
    // Released pins fall to the driver pull-downs, so a float turns off.
    assign gate_o = pins_i.level & ~pins_i.oe_n;
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_top;
    import pwcog_pkg::*;
    //--------------------------------------------------------------------------
    // Stimulus and checks
    //--------------------------------------------------------------------------
    logic        clk_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic        cutoff_event_i, count_tick_o, ext_clk_i = 1'b0;
    logic [4:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [7:0]  timer_level_i, port_level_i, port_oe_n_i, gate, m;
    logic [2:0]  counter_clear_sel_o;
    pwcog_pins_t pins_o;
    int          fail_count = 0, n_tests = 0, cnt;
    int          exp_ticks [10] = '{64, 32, 16, 8, 2, 32, 0, 32, 64, 32};
    logic [4:0]  ofs [5] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};

    // Free-running clock.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // External count clock, one period every two system clocks.
    always @(posedge clk_i) ext_clk_i <= ~ext_clk_i;

    pwcog_top #(.NUM_PINS(8)) u_pwcog_top (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_address_i(avs_address_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .timer_level_i(timer_level_i),
        .port_level_i(port_level_i), .port_oe_n_i(port_oe_n_i),
        .cutoff_event_i(cutoff_event_i), .ext_clk_i(ext_clk_i),
        .pins_o(pins_o), .count_tick_o(count_tick_o),
        .counter_clear_sel_o(counter_clear_sel_o));
    pwcog_stage_model u_pwcog_stage_model (.pins_i(pins_o), .gate_o(gate));

    // Verdict and end of run.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // One bus access; the request stands until waitrequest is seen low.
    task automatic acc(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int i;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_address_i <= a;
        avs_writedata_i <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        if (i == 20) begin
            fail_count++;
            test_done();
        end
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Read a register and compare the whole word.
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        acc(1'b0, a, 32'h0);
        `CHK("readdata", {24'h0, e}, q)
    endtask

    // Pins settle one cycle after their cause; wait a little more.
    task automatic pins(input logic [7:0] el, input logic [7:0] mk,
                        input logic [7:0] eo);
        repeat (3) @(posedge clk_i);
        `CHK("pin level", el & mk, pins_o.level & mk)
        `CHK("pin enable", eo, pins_o.oe_n)
    endtask

    initial begin
        {avs_read_i, avs_write_i, cutoff_event_i} = 3'h0;
        {avs_address_i, avs_writedata_i} = 37'h0;
        {timer_level_i, port_level_i, port_oe_n_i} = {8'h55, 8'hAA, 8'hC3};
        sys_rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values, an unmapped word, and upper bits reading zero.
        for (int k = 0; k < 5; k++) rdc(ofs[k], 8'h00);
        rdc(5'h14, 8'h00);
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, ofs[k], 32'hFFFF_FF5A);
            rdc(ofs[k], 8'h5A);
        end
        $display("test registers done");
        acc(1'b1, OFS_COUNTER0_CONTROL, 32'h0);
        acc(1'b1, OFS_CUTOFF_SELECT_CH0, 32'h0);
        acc(1'b1, OFS_CUTOFF_SELECT_CH1, 32'h0);
        acc(1'b1, OFS_OUTPUT_DISABLE, 32'h0);
        pins(8'h55, 8'hFF, 8'h00);
        acc(1'b1, OFS_OUTPUT_DISABLE, 32'h1);
        pins(8'h54, 8'hFF, 8'h01);
        for (int b = 0; b < 8; b++) begin
            m = 8'h01 << b;
            acc(1'b1, OFS_OUTPUT_DISABLE, {24'h0, m});
            pins((8'h55 & ~m) | (8'hAA & m), 8'hFF, 8'hC3 & m);
        end
        acc(1'b1, OFS_OUTPUT_DISABLE, 32'h0);
        $display("test output disable done");
        // Counting stopped before selectors change.
        acc(1'b1, OFS_COUNTER0_CONTROL, 32'hA6);
        acc(1'b1, OFS_CUTOFF_SELECT_CH0, 32'h1B);
        acc(1'b1, OFS_CUTOFF_SELECT_CH1, 32'hE4);
        pins(8'h55, 8'hFF, 8'h00);
        cutoff_event_i <= 1'b1;
        @(posedge clk_i);
        cutoff_event_i <= 1'b0;
        pins(8'h19, 8'hBD, 8'h42);
        `CHK("gate level", 8'h19, gate)
        rdc(OFS_CUTOFF_STATUS, 8'h01);
        repeat (20) @(posedge clk_i);
        pins(8'h19, 8'hBD, 8'h42);
        acc(1'b1, OFS_CUTOFF_STATUS, 32'h1);
        pins(8'h55, 8'hFF, 8'h00);
        rdc(OFS_CUTOFF_STATUS, 8'h00);
        acc(1'b1, OFS_CUTOFF_SELECT_CH0, 32'h0);
        acc(1'b1, OFS_CUTOFF_SELECT_CH1, 32'h0);
        $display("test cutoff done");
        // Tick rate of every count source, then every external edge mode.
        for (int k = 0; k < 10; k++) begin
            acc(1'b1, OFS_COUNTER0_CONTROL, {24'h0, 3'(k),
                (k < 7) ? 2'h0 : 2'(k - 6), (k < 7) ? 3'(k) : SRC_EXT});
            repeat (3) @(posedge clk_i);
            cnt = 0;
            repeat (64) begin
                @(posedge clk_i);
                cnt += (count_tick_o === 1'b1);
            end
            `CHK("clear select", 3'(k), counter_clear_sel_o)
            `CHK("tick count", exp_ticks[k], cnt)
        end
        $display("test count source done");
        test_done();
    end
endmodule
`default_nettype wire

// File: design/pwcog_pkg.sv
//------------------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------------------
// Functional notes
// RULE1 - Two-bit selector: 00 none, 01 float, 10 drive low, 11 drive high.
// RULE2 - Channel-1 selectors: bits 7:6 a1, 5:4 b1, 3:2 c1, 1:0 d1.
// RULE3 - Channel-0 bits 1:0 select pin d0 cutoff with the same encoding.
// RULE4 - Software keeps unused pins at 00; changes selectors only when stopped.
// RULE5 - Disable bit 0 lets timer drive pin; 1 hands pin to port logic.
// RULE6 - Disable bits 7..0 map to d1,c1,b1,a1,d0,c0,b0,a0.
// RULE7 - Complementary mode: software sets a0 disable bit, others stay enabled.
// RULE8 - Control: clear select 7:5, clock edge 4:3, count source 2:0.
// RULE9 - Count source 000 clocks counter 0 from the undivided system clock.
// RULE10 - On cutoff, nonzero-selector pins force state at once until cleared; the code leaves disabled pins with the port logic instead.
package pwcog_pkg;

    //--------------------------------------------------------------------------
    // Register map (byte addresses, one word each)
    //--------------------------------------------------------------------------
    localparam logic [4:0] OFS_CUTOFF_SELECT_CH0  = 5'h00;
    localparam logic [4:0] OFS_CUTOFF_SELECT_CH1  = 5'h04;
    localparam logic [4:0] OFS_OUTPUT_DISABLE     = 5'h08;
    localparam logic [4:0] OFS_COUNTER0_CONTROL   = 5'h0C;
    localparam logic [4:0] OFS_CUTOFF_STATUS      = 5'h10;

    //--------------------------------------------------------------------------
    // Reset values
    //--------------------------------------------------------------------------
    localparam logic [7:0] RST_CUTOFF_SELECT      = 8'h00;
    localparam logic [7:0] RST_OUTPUT_DISABLE     = 8'h00;
    localparam logic [7:0] RST_COUNTER0_CONTROL   = 8'h00;

    //--------------------------------------------------------------------------
    // Field positions
    //--------------------------------------------------------------------------
    localparam int CCLR_MSB   = 7;
    localparam int CCLR_LSB   = 5;
    localparam int CKEG_MSB   = 4;
    localparam int CKEG_LSB   = 3;
    localparam int TCK_MSB    = 2;
    localparam int TCK_LSB    = 0;
    localparam int STAT_ACTIVE = 0;
    localparam int PINS_PER_CH = 4;

    //--------------------------------------------------------------------------
    // Encodings
    //--------------------------------------------------------------------------
    localparam logic [1:0] CUT_NONE  = 2'h0;
    localparam logic [1:0] CUT_FLOAT = 2'h1;
    localparam logic [1:0] CUT_LOW   = 2'h2;
    localparam logic [1:0] CUT_HIGH  = 2'h3;

    localparam logic [2:0] SRC_DIV1  = 3'h0;
    localparam logic [2:0] SRC_DIV2  = 3'h1;
    localparam logic [2:0] SRC_DIV4  = 3'h2;
    localparam logic [2:0] SRC_DIV8  = 3'h3;
    localparam logic [2:0] SRC_DIV32 = 3'h4;
    localparam logic [2:0] SRC_EXT   = 3'h5;

    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    //--------------------------------------------------------------------------
    // Carriers
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
    } pwcog_avmm_req_t;

    typedef struct packed {
        logic [7:0] level;   // Timer, port or forced cutoff level per pin.
        logic [7:0] oe_n;    // Low while the pin is driven.
    } pwcog_pins_t;

endpackage

// File: design/pwcog_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module pwcog_prescaler
    import pwcog_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Selection.
    input  wire logic [2:0] source_sel_i,
    input  wire logic [1:0] edge_sel_i,
    input  wire logic       ext_clk_i,
    // Count enable for counter 0.
    output logic            count_tick_o
);
    import pwcog_pkg::*;

    logic [4:0] div_cnt;
    logic [4:0] next_div_cnt;
    logic       ext_prev;
    logic       next_ext_prev;
    logic       next_tick;
    logic       rise;
    logic       fall;

    //--------------------------------------------------------------------------
    // Divider and external edge detection
    //--------------------------------------------------------------------------
    // The divider runs freely; a tick is a whole-period marker, so a source
    // change mid-count only shifts the first tick, which is why changes are
    // made while counting is stopped.
    always_comb begin
        next_div_cnt  = div_cnt + 5'h01;
        next_ext_prev = ext_clk_i;
        rise          = ext_clk_i & ~ext_prev;
        fall          = ~ext_clk_i & ext_prev;
        case (source_sel_i)
            SRC_DIV1:  next_tick = 1'b1;                         // [RULE9]
            SRC_DIV2:  next_tick = (next_div_cnt[0:0] == 1'h0);
            SRC_DIV4:  next_tick = (next_div_cnt[1:0] == 2'h0);
            SRC_DIV8:  next_tick = (next_div_cnt[2:0] == 3'h0);
            SRC_DIV32: next_tick = (next_div_cnt == 5'h00);
            SRC_EXT: begin
                case (edge_sel_i)
                    EDGE_FALL: next_tick = fall;
                    EDGE_BOTH: next_tick = rise | fall;
                    default:   next_tick = rise;
                endcase
            end
            default:   next_tick = 1'b0;   // Reserved codes count nothing.
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_cnt      <= 5'h00;
            ext_prev     <= 1'b0;
            count_tick_o <= 1'b0;
        end else begin
            div_cnt      <= next_div_cnt;
            ext_prev     <= next_ext_prev;
            count_tick_o <= next_tick;
        end
    end

endmodule
`default_nettype wire

// File: design/pwcog_top.sv
`timescale 1ns/10ps
`default_nettype none
module pwcog_top
    import pwcog_pkg::*;
#(
    parameter int NUM_PINS = 8
)(
    // Clock and reset.
    input  wire logic                  clk_i,
    input  wire logic                  sys_rst_i,
    // Avalon-MM slave.
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [4:0]            avs_address_i,
    input  wire logic [31:0]           avs_writedata_i,
    output logic [31:0]                avs_readdata_o,
    output logic                       avs_waitrequest_o,
    // Timer waveforms and general port logic, one bit per pin.
    input  wire logic [NUM_PINS-1:0]   timer_level_i,
    input  wire logic [NUM_PINS-1:0]   port_level_i,
    input  wire logic [NUM_PINS-1:0]   port_oe_n_i,
    // Cutoff event and external count clock.
    input  wire logic                  cutoff_event_i,
    input  wire logic                  ext_clk_i,
    // Pins and count enable.
    output pwcog_pkg::pwcog_pins_t     pins_o,
    output logic                       count_tick_o,
    output logic [2:0]                 counter_clear_sel_o
);
    import pwcog_pkg::*;

    //--------------------------------------------------------------------------
    // Elaboration check
    //--------------------------------------------------------------------------
    // The register layout holds exactly two channels of four pins.
    // Pin index p maps straight onto output-disable bit p, so the mask
    // layout fixes the pin count as well. A wrong count stops elaboration
    // rather than building a half-mapped output stage.
    if (NUM_PINS != 2 * PINS_PER_CH) begin : g_bad_pins
        $error("pwcog_top: NUM_PINS must equal 8");
    end

    // Bus request gathered into one carrier for the decode below.
    pwcog_avmm_req_t req;
    assign req = '{read: avs_read_i, write: avs_write_i,
                   address: avs_address_i, writedata: avs_writedata_i};

    // Software-visible registers and the cutoff latch.
    logic [7:0]  cutoff_select_ch0;
    logic [7:0]  cutoff_select_ch1;
    logic [7:0]  output_disable_mask;
    logic [7:0]  counter0_control;
    logic        cutoff_active;

    // Their next values, and the next values of the bus outputs.
    logic [7:0]  next_cutoff_select_ch0;
    logic [7:0]  next_cutoff_select_ch1;
    logic [7:0]  next_output_disable_mask;
    logic [7:0]  next_counter0_control;
    logic        next_cutoff_active;
    logic [31:0] next_readdata;
    logic        next_waitrequest;
    logic [2:0]  next_clear_sel;

    // Handshake decode: take opens an access, commit lands a write.
    logic        take;
    logic        commit;
    logic        clear_cutoff;
    logic        cut_now;

    // Per-pin next values, gathered for the single pin register process.
    logic [7:0]  next_pin_level;
    logic [7:0]  next_pin_oe_n;

    //--------------------------------------------------------------------------
    // Bus slave and register file
    //--------------------------------------------------------------------------
    // Every access takes exactly one wait cycle. Waitrequest idles high; the
    // edge that sees a request with waitrequest high takes it and drops
    // waitrequest for one cycle, registering read data at the same time.
    // A write lands only at the next edge, where the master sees waitrequest
    // low, so a write never takes effect before the master completes it.
    // Reads have no side effects, so their early capture is safe.
    // The price is a fixed two-cycle access; back-to-back requests see one
    // transfer every two cycles, which register setup easily tolerates.
    always_comb begin
        take                     = (req.read | req.write) & avs_waitrequest_o;
        commit                   = req.write & ~avs_waitrequest_o;
        next_waitrequest         = ~take;
        next_cutoff_select_ch0   = cutoff_select_ch0;
        next_cutoff_select_ch1   = cutoff_select_ch1;
        next_output_disable_mask = output_disable_mask;
        next_counter0_control    = counter0_control;
        next_readdata            = avs_readdata_o;
        clear_cutoff             = 1'b0;
        // Writes land at the completing edge only.
        if (commit) begin
            case (req.address)
                OFS_CUTOFF_SELECT_CH0:
                    next_cutoff_select_ch0 = req.writedata[7:0];   // [RULE3]
                OFS_CUTOFF_SELECT_CH1:
                    next_cutoff_select_ch1 = req.writedata[7:0];   // [RULE2]
                OFS_OUTPUT_DISABLE:
                    next_output_disable_mask = req.writedata[7:0]; // [RULE6]
                OFS_COUNTER0_CONTROL:
                    next_counter0_control = req.writedata[7:0];    // [RULE8]
                OFS_CUTOFF_STATUS:
                    clear_cutoff = req.writedata[STAT_ACTIVE];
                default: ;                 // Unmapped writes are dropped.
            endcase
        end
        // Unmapped reads return zero; upper bits of every word read as zero.
        if (take && req.read) begin
            case (req.address)
                OFS_CUTOFF_SELECT_CH0: next_readdata = {24'h0, cutoff_select_ch0};
                OFS_CUTOFF_SELECT_CH1: next_readdata = {24'h0, cutoff_select_ch1};
                OFS_OUTPUT_DISABLE:    next_readdata = {24'h0, output_disable_mask};
                OFS_COUNTER0_CONTROL:  next_readdata = {24'h0, counter0_control};
                OFS_CUTOFF_STATUS:     next_readdata = {31'h0, cutoff_active};
                default:               next_readdata = 32'h0;
            endcase
        end
        // The latch clears only by reset or by a software write of one to the status
        // bit; a new event in the clearing cycle keeps the latch set, so an
        // event is never lost between a read of the status and its clear.
        cut_now            = cutoff_active | cutoff_event_i;
        next_cutoff_active = cutoff_event_i |
                             (cutoff_active & ~clear_cutoff);      // [RULE10]
        // The clear select is only stored and passed on; the counter that
        // uses it sits outside this block.
        next_clear_sel     = counter0_control[CCLR_MSB:CCLR_LSB];  // [RULE8]
    end

    // Register stage for the bus outputs, the register file and the latch.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cutoff_select_ch0   <= RST_CUTOFF_SELECT;
            cutoff_select_ch1   <= RST_CUTOFF_SELECT;
            output_disable_mask <= RST_OUTPUT_DISABLE;
            counter0_control    <= RST_COUNTER0_CONTROL;
            cutoff_active       <= 1'b0;
            avs_readdata_o      <= 32'h0;
            avs_waitrequest_o   <= 1'b1;
            counter_clear_sel_o <= 3'h0;
        end else begin
            cutoff_select_ch0   <= next_cutoff_select_ch0;
            cutoff_select_ch1   <= next_cutoff_select_ch1;
            output_disable_mask <= next_output_disable_mask;
            counter0_control    <= next_counter0_control;
            cutoff_active       <= next_cutoff_active;
            avs_readdata_o      <= next_readdata;
            avs_waitrequest_o   <= next_waitrequest;
            counter_clear_sel_o <= next_clear_sel;
        end
    end

    //--------------------------------------------------------------------------
    // Pin output stage
    //--------------------------------------------------------------------------
    // Pin k of a channel takes selector bits [7-2k:6-2k]; index 0..3 is
    // a0..d0 and 4..7 is a1..d1. The incoming event is used directly so the
    // forced state reaches the pins on the very next edge.
    // A disabled pin belongs to the port logic even during a cutoff, since
    // the port logic then owns the pin and the timer must not fight it.
    // Selector 00 leaves the timer waveform in place.
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        localparam int K = p % PINS_PER_CH;
        logic [1:0] sel;
        logic       next_level;
        logic       next_oe_n;
        assign sel = (p < PINS_PER_CH) ? cutoff_select_ch0[7-2*K -: 2]
                                       : cutoff_select_ch1[7-2*K -: 2];
        always_comb begin
            next_level = timer_level_i[p];
            next_oe_n  = 1'b0;
            if (output_disable_mask[p]) begin                      // [RULE5]
                next_level = port_level_i[p];
                next_oe_n  = port_oe_n_i[p];
            end else if (cut_now) begin                            // [RULE10]
                case (sel)                                         // [RULE1]
                    CUT_FLOAT: next_oe_n  = 1'b1;
                    CUT_LOW:   next_level = 1'b0;
                    CUT_HIGH:  next_level = 1'b1;
                    default:   next_level = timer_level_i[p];
                endcase
            end
        end
        assign next_pin_level[p] = next_level;
        assign next_pin_oe_n[p]  = next_oe_n;
    end

    // One process registers all pins so the struct output has one driver.
    // Reset releases every pin: a gate stage with pull-downs then holds the
    // power switches off while reset lasts; the first edge after it drives the timer levels.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pins_o.level <= 8'h00;
            pins_o.oe_n  <= 8'hFF;
        end else begin
            pins_o.level <= next_pin_level;
            pins_o.oe_n  <= next_pin_oe_n;
        end
    end

    //--------------------------------------------------------------------------
    // Count source
    //--------------------------------------------------------------------------
    // The prescaler only forms a one-cycle count enable; counter 0 keeps
    // running on clk_i and never on a derived clock, which keeps the whole
    // timer in one clock domain. Reserved source codes are stored as
    // written and simply produce no enable.
    pwcog_prescaler u_prescaler (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .source_sel_i (counter0_control[TCK_MSB:TCK_LSB]),         // [RULE9]
        .edge_sel_i   (counter0_control[CKEG_MSB:CKEG_LSB]),
        .ext_clk_i    (ext_clk_i),
        .count_tick_o (count_tick_o)
    );

endmodule
`default_nettype wire
